// >>> rtl/wdc_watchdog_wake.sv
// Watchdog timer with key-protected enable and the wake-up control of the core.
//
// Summary of operation
// - While halted, wake on enabled port A falling edge, interrupt or watchdog overflow.
// - Halt sets power-down flag; only power-up or clear-watchdog clears it.
// - Overflow while halted sets time-out flag, resets only PC and stack pointer.
// - Each port A pin has a wake enable; pin wake resumes after halt.
// - Disabled or stack-full interrupt wake resumes after halt; request stays pending.
// - Enabled interrupt with free stack level gets normal response on wake-up.
// - Interrupt flag already set on halt entry does not wake.
// - Sleep to fast wake waits for selected fast oscillator stable flag.
// - Peripherals on system clock follow system clock source switches.
// - Watchdog counts slow RC clock, divided 2^8 to 2^18.
// - Select codes 000 to 110 give 2^8,10,12,14,15,16,17 periods.
// - Key 01010 enables, 10101 disables, other values reset after delay.
// - Key fault reset sets key fault flag in reset cause register.
// - Key fault flag set only by hardware, cleared only by writing zero.
// - Key field holds 01010 after power-on.
// - Normal-mode overflow requests device reset and sets time-out flag.
// - Count cleared by key fault, clear-watchdog instruction or halt.
// - Reset cause bits 7 to 4 read as zero.
`timescale 1ns/10ps
`default_nettype none
module wdc_watchdog_wake (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Slow RC clock and port A pins
	input  wire logic        slowRcClk,
	input  wire logic [7:0]  portA,
	// Core
	input  wire logic        haltExec,
	input  wire logic        clearWatchdogInstr,
	input  wire logic        powerUp,
	input  wire logic        fastModeWake,
	input  wire logic        useFastCrystal,
	input  wire logic        fastRcStable,
	input  wire logic        fastCrystalStable,
	input  wire logic        irqRequest,
	input  wire logic        irqEnabled,
	input  wire logic        stackFull,
	input  wire logic        extResetCause0,
	input  wire logic        extResetCause1,
	input  wire logic        extResetCause2,
	output var  logic        resetRequest,
	output var  logic        pcSpReset,
	output var  logic        coreHalted,
	output var  logic        resumeAfterHalt,
	output var  logic        serviceIrq,
	output var  logic        powerDownFlag,
	output var  logic        timeoutFlag
);
	wdc_pkg::wdc_state_type s_reg;
	wdc_pkg::wdc_state_type s_next;
	logic        irqAtEntry_reg;

	function automatic logic [18:0] period(input logic [2:0] sel);
		case (sel)
			3'h0: period = 19'h00100;
			3'h1: period = 19'h00400;
			3'h2: period = 19'h01000;
			3'h3: period = 19'h04000;
			3'h4: period = 19'h08000;
			3'h5: period = 19'h10000;
			3'h6: period = 19'h20000;
			default: period = 19'h40000;
		endcase
	endfunction : period

	logic        wr;
	logic        rd;
	logic        keyOk;
	logic        wdtOn;
	logic        tick;
	logic        ovf;
	logic [7:0]  paFall;
	logic        oscOk;
	logic        irqWake;

	always_comb begin
		s_next = s_reg;
		wr = psel && penable && pwrite;
		rd = psel && !penable && !pwrite;
		keyOk = (s_reg.ctrl[7:3] == wdc_pkg::KEY_ENABLE) || (s_reg.ctrl[7:3] == wdc_pkg::KEY_DISABLE);
		wdtOn = s_reg.ctrl[7:3] == wdc_pkg::KEY_ENABLE;
		// Synchronisers; the second stage is read, and for edge detection also a third stage.
		s_next.lircSync = {s_reg.lircSync[1:0], slowRcClk};
		s_next.paSync1 = portA;
		s_next.paSync2 = s_reg.paSync1;
		s_next.paPrev = s_reg.paSync2;
		s_next.oscSync1 = {fastCrystalStable, fastRcStable};
		s_next.oscSync2 = s_reg.oscSync1;
		tick = s_reg.lircSync[1] && !s_reg.lircSync[2];
		paFall = s_reg.paPrev & ~s_reg.paSync2 & s_reg.wakeMask;
		oscOk = useFastCrystal ? s_reg.oscSync2[1] : s_reg.oscSync2[0];
		irqWake = irqRequest && !irqAtEntry_reg;
		s_next.rstReq = 1'b0;
		s_next.pcReset = 1'b0;
		s_next.wakeIrq = 1'b0;
		s_next.resume = 1'b0;
		ovf = 1'b0;
		if (wdtOn && tick) begin
			if (s_reg.count + 19'h1 >= period(s_reg.ctrl[2:0])) begin
				ovf = 1'b1;
				s_next.count = '0;
			end else begin
				s_next.count = s_reg.count + 19'h1;
			end
		end
		if (clearWatchdogInstr) begin
			s_next.count = '0;
			s_next.powerDown = 1'b0;
			s_next.timeout = 1'b0;
		end
		if (powerUp)
			s_next.powerDown = 1'b0;
		// Key fault countdown then reset.
		if (!keyOk && !s_reg.faultPend) begin
			s_next.faultPend = 1'b1;
			s_next.faultCnt = wdc_pkg::REG_FAULT_RESET_CYCLES;
		end else if (s_reg.faultPend) begin
			if (s_reg.faultCnt <= 16'h1) begin
				s_next.faultPend = 1'b0;
				s_next.rstReq = 1'b1;
				s_next.count = '0;
				s_next.ctrl = wdc_pkg::WDC_CTRL_RESET;
			end else begin
				s_next.faultCnt = s_reg.faultCnt - 16'h1;
			end
		end
		case (s_reg.mode)
			wdc_pkg::RUN: begin
				if (haltExec) begin
					s_next.mode = wdc_pkg::HALTED;
					s_next.powerDown = 1'b1;
					s_next.timeout = 1'b0;
					s_next.count = '0;
				end else if (ovf) begin
					s_next.timeout = 1'b1;
					s_next.rstReq = 1'b1;
				end
			end
			wdc_pkg::HALTED: begin
				if (ovf) begin
					s_next.timeout = 1'b1;
					s_next.pcReset = 1'b1;
					s_next.mode = wdc_pkg::WAIT_OSC;
				end else if (paFall != 8'h00 || irqWake) begin
					s_next.wakeIrq = irqWake && irqEnabled && !stackFull;
					s_next.mode = wdc_pkg::WAIT_OSC;
				end
			end
			wdc_pkg::WAIT_OSC: begin
				if (!fastModeWake || oscOk) begin
					s_next.mode = wdc_pkg::RUN;
					s_next.resume = 1'b1;
					s_next.wakeIrq = s_reg.wakeIrq;
				end else begin
					s_next.wakeIrq = s_reg.wakeIrq;
				end
			end
			default: s_next.mode = wdc_pkg::RUN;
		endcase
		// Register writes; hardware set of key fault flag wins.
		if (wr) begin
			case (paddr)
				wdc_pkg::WATCHDOG_CONTROL_OFFS: s_next.ctrl = pwdata[7:0];
				wdc_pkg::RESET_CAUSE_FLAGS_OFFS: s_next.cause = s_reg.cause & pwdata[3:0];
				wdc_pkg::WAKE_MASK_OFFS: s_next.wakeMask = pwdata[7:0];
				default: ;
			endcase
		end
		if (extResetCause0)
			s_next.cause[1] = 1'b1;
		if (extResetCause1)
			s_next.cause[2] = 1'b1;
		if (extResetCause2)
			s_next.cause[3] = 1'b1;
		if (s_next.rstReq && s_reg.faultPend)
			s_next.cause[wdc_pkg::KEY_FAULT_BIT] = 1'b1;
		if (rd) begin
			case (paddr)
				wdc_pkg::WATCHDOG_CONTROL_OFFS: s_next.prdata = {24'h0, s_reg.ctrl};
				wdc_pkg::RESET_CAUSE_FLAGS_OFFS: s_next.prdata = {28'h0, s_reg.cause};
				wdc_pkg::WAKE_MASK_OFFS: s_next.prdata = {24'h0, s_reg.wakeMask};
				wdc_pkg::CORE_STATUS_OFFS: s_next.prdata = {28'h0, s_reg.mode, s_reg.timeout, s_reg.powerDown};
				default: s_next.prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
			s_reg.ctrl <= wdc_pkg::WDC_CTRL_RESET;
			s_reg.wakeMask <= wdc_pkg::WAKE_MASK_RESET;
			s_reg.lircSync <= wdc_pkg::SYNC_RESET;
			s_reg.mode <= wdc_pkg::RUN;
			irqAtEntry_reg <= 1'b0;
		end else begin
			s_reg <= s_next;
			if (s_reg.mode == wdc_pkg::RUN && haltExec)
				irqAtEntry_reg <= irqRequest;
			else if (!irqRequest)
				irqAtEntry_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Outputs
	// System clock peripherals are clocked outside this block and follow the source switch.
	assign prdata = s_reg.prdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign resetRequest = s_reg.rstReq;
	assign pcSpReset = s_reg.pcReset;
	assign coreHalted = s_reg.mode != wdc_pkg::RUN;
	assign resumeAfterHalt = s_reg.resume;
	assign serviceIrq = s_reg.resume && s_reg.wakeIrq;
	assign powerDownFlag = s_reg.powerDown;
	assign timeoutFlag = s_reg.timeout;

	// ==========================================================
	// Assertions
	sequence haltSeq;
		s_reg.mode == wdc_pkg::RUN && haltExec && !clearWatchdogInstr;
	endsequence
	haltSets_a: assert property (@(posedge clk_sys) disable iff (!rstn) haltSeq |=> powerDownFlag)
		else $error("halt did not set power-down flag");
	haltClears_a: assert property (@(posedge clk_sys) disable iff (!rstn) haltSeq |=> s_reg.count == 19'h0)
		else $error("halt did not clear count");
	clrClears_a: assert property (@(posedge clk_sys) disable iff (!rstn) clearWatchdogInstr |=> !powerDownFlag)
		else $error("clear did not clear power-down");
	sleepOvf_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_reg.mode == wdc_pkg::HALTED && ovf |=> pcSpReset && timeoutFlag && !resetRequest)
		else $error("sleep overflow handled wrong");
	runOvf_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_reg.mode == wdc_pkg::RUN && ovf && !haltExec && !clearWatchdogInstr |=> resetRequest && timeoutFlag)
		else $error("run overflow handled wrong");
	oscWait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_reg.mode == wdc_pkg::WAIT_OSC && fastModeWake && !oscOk |=> !resumeAfterHalt)
		else $error("resumed before oscillator stable");
	causeHigh_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		rd && paddr == wdc_pkg::RESET_CAUSE_FLAGS_OFFS |=> prdata[31:4] == 28'h0)
		else $error("cause upper bits nonzero");
	keyFault_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		resetRequest && $past(s_reg.faultPend) |-> s_reg.cause[0])
		else $error("key fault flag not set");
	periodMax_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		wdtOn |-> s_reg.count < period(s_reg.ctrl[2:0]))
		else $error("count beyond period");
endmodule : wdc_watchdog_wake
`default_nettype wire

// >>> rtl/wdc_pkg.sv
// Package with register map, field layout, reset values and timing constants of the watchdog block.
package wdc_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] WATCHDOG_CONTROL_OFFS  = 12'h000;
	localparam logic [11:0] RESET_CAUSE_FLAGS_OFFS = 12'h004;
	localparam logic [11:0] WAKE_MASK_OFFS         = 12'h008;
	localparam logic [11:0] CORE_STATUS_OFFS       = 12'h00C;
	// ==========================================================
	// Fields and reset values
	localparam int          KEY_LSB         = 3;
	localparam logic [7:0]  WDC_CTRL_RESET  = 8'h53;
	localparam logic [4:0]  KEY_ENABLE      = 5'h0A;
	localparam logic [4:0]  KEY_DISABLE     = 5'h15;
	localparam logic [7:0]  WAKE_MASK_RESET = 8'h00;
	localparam int          KEY_FAULT_BIT   = 0;
	// ==========================================================
	// Timing
	localparam int          REG_FAULT_RESET_DELAY_NS = 100;
	localparam int          CLK_PERIOD_NS            = 5;
	localparam logic [15:0] REG_FAULT_RESET_CYCLES   =
		16'((REG_FAULT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0]  SYNC_RESET               = 3'h0;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {RUN, HALTED, WAIT_OSC} wdc_mode_type;
	typedef struct packed {
		logic [7:0]   ctrl;
		logic [3:0]   cause;
		logic [7:0]   wakeMask;
		logic         powerDown;
		logic         timeout;
		logic [18:0]  count;
		logic [2:0]   lircSync;
		logic [7:0]   paSync1;
		logic [7:0]   paSync2;
		logic [7:0]   paPrev;
		logic [1:0]   oscSync1;
		logic [1:0]   oscSync2;
		logic         faultPend;
		logic [15:0]  faultCnt;
		wdc_mode_type mode;
		logic         rstReq;
		logic         pcReset;
		logic         wakeIrq;
		logic         resume;
		logic [31:0]  prdata;
	} wdc_state_type;
endpackage : wdc_pkg

// >>> testbench/watchdog_and_wakeup_control_test.sv
// Self-checking testbench of the watchdog and wake-up block.
`timescale 1ns/10ps
`default_nettype none
module watchdog_and_wakeup_control_test;
	// ==========================================================
	// Signals
	logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        slowRcClk, haltExec, clearWatchdogInstr, fastModeWake, useFastCrystal, fastCrystalStable;
	logic        irqRequest, irqEnabled, stackFull, resetRequest, pcSpReset, coreHalted;
	logic        resumeAfterHalt, serviceIrq, powerDownFlag, timeoutFlag;
	logic [7:0]  portA;
	logic [1:0]  slowDiv;
	int          cyc, n_mismatch, n_compared, nRst, nRes, nSvc, nPc, t0, b0, b1, ex;
	wdc_watchdog_wake u_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.slowRcClk(slowRcClk), .portA(portA), .haltExec(haltExec), .clearWatchdogInstr(clearWatchdogInstr),
		.powerUp(1'b0), .fastModeWake(fastModeWake), .useFastCrystal(useFastCrystal), .fastRcStable(1'b1),
		.fastCrystalStable(fastCrystalStable), .irqRequest(irqRequest), .irqEnabled(irqEnabled),
		.stackFull(stackFull), .extResetCause0(1'b0), .extResetCause1(1'b0), .extResetCause2(1'b0),
		.resetRequest(resetRequest), .pcSpReset(pcSpReset), .coreHalted(coreHalted),
		.resumeAfterHalt(resumeAfterHalt), .serviceIrq(serviceIrq), .powerDownFlag(powerDownFlag),
		.timeoutFlag(timeoutFlag));
	// ==========================================================
	// Clock, slow clock, pulse counters and timeout
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	assign slowRcClk = slowDiv[1];
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		slowDiv <= slowDiv + 2'h1;
		if (resetRequest === 1'b1) nRst <= nRst + 1;
		if (resumeAfterHalt === 1'b1) nRes <= nRes + 1;
		if (serviceIrq === 1'b1) nSvc <= nSvc + 1;
		if (pcSpReset === 1'b1) nPc <= nPc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			complete_run();
		end
	end
	// ==========================================================
	// Tasks
	task complete_run();
		$display("mismatches %0d, comparisons %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task pulse(input logic clr);
		@(posedge clk_sys);
		haltExec <= ~clr;
		clearWatchdogInstr <= clr;
		@(posedge clk_sys);
		haltExec <= 1'b0;
		clearWatchdogInstr <= 1'b0;
	endtask : pulse
	task wake(input logic [31:0] expRes, input logic [31:0] expSvc, input string name);
		b0 = nRes;
		b1 = nSvc;
		tick(40);
		chk({name, " resume"}, expRes, nRes - b0);
		chk({name, " service"}, expSvc, nSvc - b1);
	endtask : wake
	// ==========================================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, haltExec, clearWatchdogInstr} = '0;
		{fastModeWake, useFastCrystal, fastCrystalStable, irqRequest, irqEnabled, stackFull} = '0;
		{cyc, n_mismatch, n_compared, nRst, nRes, nSvc, nPc} = '0;
		slowDiv = 2'h0;
		portA = 8'hFF;
		rstn = 1'b0;
		tick(2);
		rstn <= 1'b1;
		apb(1'b0, wdc_pkg::WATCHDOG_CONTROL_OFFS, 32'h0);
		chk("control", 32'h53, rd);
		chk("slave error", 32'h0, 32'(pslverr));
		apb(1'b0, wdc_pkg::RESET_CAUSE_FLAGS_OFFS, 32'h0);
		chk("cause upper", 32'h0, rd & 32'hFFFFFFF0);
		t0 = nRst;
		apb(1'b1, wdc_pkg::WATCHDOG_CONTROL_OFFS, 32'hF8);
		tick(8);
		chk("early fault", 32'h0, nRst - t0);
		tick(30);
		chk("fault reset", 32'h1, nRst - t0);
		apb(1'b0, wdc_pkg::RESET_CAUSE_FLAGS_OFFS, 32'h0);
		chk("fault flag", 32'h1, rd & 32'h1);
		apb(1'b1, wdc_pkg::RESET_CAUSE_FLAGS_OFFS, 32'h0);
		apb(1'b0, wdc_pkg::RESET_CAUSE_FLAGS_OFFS, 32'h0);
		chk("flag clear", 32'h0, rd & 32'h1);
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, wdc_pkg::WATCHDOG_CONTROL_OFFS, {24'h0, wdc_pkg::KEY_ENABLE, 3'(s)});
			pulse(1'b1);
			t0 = cyc;
			b0 = nRst;
			ex = 4 << (8 + 2 * s);
			while (nRst == b0 && cyc - t0 < 6000) tick(1);
			chk("period", 32'h1, 32'(cyc - t0 > ex - 30 && cyc - t0 < ex + 40));
			chk("timeout flag", 32'h1, 32'(timeoutFlag));
		end
		apb(1'b1, wdc_pkg::WATCHDOG_CONTROL_OFFS, {24'h0, wdc_pkg::KEY_DISABLE, 3'h0});
		pulse(1'b1);
		b0 = nRst;
		tick(1500);
		chk("disabled", 32'h0, nRst - b0);
		apb(1'b1, wdc_pkg::WAKE_MASK_OFFS, 32'h01);
		pulse(1'b0);
		tick(3);
		chk("halted", 32'h1, 32'(coreHalted & powerDownFlag));
		portA <= 8'hFD;
		wake(32'h0, 32'h0, "masked pin");
		portA <= 8'hFC;
		wake(32'h1, 32'h0, "pin");
		portA <= 8'hFF;
		chk("flag kept", 32'h1, 32'(powerDownFlag));
		pulse(1'b1);
		tick(2);
		chk("flag cleared", 32'h0, 32'(powerDownFlag));
		for (int k = 0; k < 3; k++) begin
			irqEnabled <= (k != 1);
			stackFull <= (k == 2);
			pulse(1'b0);
			tick(3);
			irqRequest <= 1'b1;
			wake(32'h1, 32'(k == 0), "irq");
			irqRequest <= 1'b0;
		end
		irqRequest <= 1'b1;
		pulse(1'b0);
		wake(32'h0, 32'h0, "pending irq");
		irqRequest <= 1'b0;
		portA <= 8'hFE;
		wake(32'h1, 32'h0, "pin after");
		portA <= 8'hFF;
		{fastModeWake, useFastCrystal} <= 2'h3;
		pulse(1'b0);
		portA <= 8'hFE;
		wake(32'h0, 32'h0, "osc wait");
		fastCrystalStable <= 1'b1;
		wake(32'h1, 32'h0, "osc ok");
		portA <= 8'hFF;
		apb(1'b1, wdc_pkg::WATCHDOG_CONTROL_OFFS, {24'h0, wdc_pkg::KEY_ENABLE, 3'h0});
		pulse(1'b0);
		b0 = nRst;
		b1 = nPc;
		tick(1200);
		chk("halt overflow", 32'h1, nPc - b1);
		chk("no device reset", 32'h0, nRst - b0);
		chk("halt flags", 32'h1, 32'(timeoutFlag & powerDownFlag));
		complete_run();
	end
endmodule : watchdog_and_wakeup_control_test
`default_nettype wire
